// ---- hdl/uht_irq.sv ----
// sticky event status with write-one-to-clear and a mask onto one level output
// assumes single-cycle event pulses
`timescale 1ns/100ps
module uht_irq
   import uht_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic [UHT_IRQ_W-1:0] events,
   input  wire logic                 stat_wr,
   input  wire logic                 mask_wr,
   input  wire logic [UHT_IRQ_W-1:0] wdata,
   output logic      [UHT_IRQ_W-1:0] status,
   output logic      [UHT_IRQ_W-1:0] mask,
   output logic                      irq
);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status <= '0;
      end else begin
         // set wins over a clear in the same cycle
         status <= (status & ~(stat_wr ? wdata : '0)) | events;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mask <= UHT_IRQ_MASK_RST;
      end else if (mask_wr) begin
         mask <= wdata;
      end
   end

   assign irq = |(status & mask);
endmodule

// ---- hdl/uht_nak_timer.sv ----
// endpoint 0 nak timeout: counts frames of unbroken naks and halts the endpoint
// assumes one-cycle frame_tick and nak_seen pulses from the transaction engine
`timescale 1ns/100ps
module uht_nak_timer
   import uht_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    enable,
   input  wire logic [UHT_NAKLIM_W-1:0] limit,
   input  wire logic                    frame_tick,
   input  wire logic                    nak_seen,
   input  wire logic                    data_seen,
   input  wire logic                    halt_clr,
   output logic                         halt,
   output logic                         halt_pulse
);
   logic [16:0] frames_r;
   logic [16:0] span;
   logic        active_r;
   logic        expire;

   // 2^(m-1) frames; 0 and 1 disable the timeout
   assign span   = 17'h00001 << (limit - 5'h01);
   assign expire = enable && (limit >= UHT_NAKLIM_MIN) && active_r && frame_tick
                   && (frames_r >= span) && !halt;

   // a halted endpoint or a disabled timeout waits for a fresh nak stream
   always_ff @(posedge clk) begin
      if (!rst_n || data_seen || !enable || halt || limit < UHT_NAKLIM_MIN) begin
         active_r <= 1'b0;
         frames_r <= 17'h00000;
      end else if (nak_seen) begin
         active_r <= 1'b1;
      end else if (frame_tick && active_r && frames_r != 17'h1FFFF) begin
         frames_r <= frames_r + 17'h00001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         halt <= 1'b0;
      end else if (expire) begin
         halt <= 1'b1;
      end else if (halt_clr) begin
         halt <= 1'b0;
      end
   end

   assign halt_pulse = expire;
endmodule

// ---- hdl/uht_pkg.sv ----
// package of register map, field layout and reset values for the endpoint type registers
// assumes a plain register port with word indices; no bus wider than 16 bits
package uht_pkg;
   localparam int          UHT_ADDR_W        = 4;
   localparam logic [3:0]  UHT_IDX_RX_COUNT  = 4'h0;
   localparam logic [3:0]  UHT_IDX_EP0_TYPE  = 4'h1;
   localparam logic [3:0]  UHT_IDX_TX_TYPE   = 4'h2;
   localparam logic [3:0]  UHT_IDX_NAK_LIM0  = 4'h3;
   localparam logic [3:0]  UHT_IDX_IRQ_STAT  = 4'h4;
   localparam logic [3:0]  UHT_IDX_IRQ_MASK  = 4'h5;
   localparam logic [3:0]  UHT_IDX_EP0_CTRL  = 4'h6;
   localparam int          UHT_CNT_W         = 13;
   localparam int          UHT_SPEED_LSB     = 6;
   localparam int          UHT_PROTOCOL_SELECT_LSB      = 4;
   localparam int          UHT_TEP_LSB       = 0;
   localparam int          UHT_NAKLIM_W      = 5;
   localparam logic [1:0]  UHT_SPEED_ILLEGAL = 2'h0;
   localparam logic [1:0]  UHT_SPEED_HIGH    = 2'h1;
   localparam logic [1:0]  UHT_SPEED_FULL    = 2'h2;
   localparam logic [1:0]  UHT_SPEED_LOW     = 2'h3;
   localparam logic [1:0]  UHT_PROTOCOL_SELECT_CTRL     = 2'h0;
   localparam logic [1:0]  UHT_PROTOCOL_SELECT_ISO      = 2'h1;
   localparam logic [1:0]  UHT_PROTOCOL_SELECT_BULK     = 2'h2;
   localparam logic [1:0]  UHT_PROTOCOL_SELECT_INT      = 2'h3;
   localparam logic [7:0]  UHT_EP0_TYPE_RST  = 8'h00;
   localparam logic [7:0]  UHT_TX_TYPE_RST   = 8'h00;
   localparam logic [4:0]  UHT_NAKLIM_RST    = 5'h00;
   localparam logic [4:0]  UHT_NAKLIM_MIN    = 5'h02;
   localparam logic [4:0]  UHT_NAKLIM_MAX    = 5'h10;
   localparam int          UHT_IRQ_W         = 2;
   localparam int          UHT_IRQ_HALT      = 0;
   localparam int          UHT_IRQ_RXRDY     = 1;
   localparam logic [1:0]  UHT_IRQ_MASK_RST  = 2'h0;
endpackage

// ---- hdl/uht_regs.sv ----
// endpoint type register slice: receive count, ep0/tx target setup, ep0 nak timeout
// assumes a single-cycle register port and a transaction engine supplying events
`timescale 1ns/100ps
import uht_pkg::*;

// Behaviour
// - read-only 13-bit count of received packet bytes in the receive fifo
// - count follows fifo contents; valid only while rx packet ready is set
// - ep0 type holds 2-bit target speed in bits 7-6; 1 high, 2 full, 3 low
// - tx type holds 2-bit target speed in bits 7-6 with the same codes
// - tx protocol field: 0 control, 1 iso, 2 bulk, 3 interrupt
// - software writes target endpoint number; device sends it for tx transactions
// - ep0 nak limit m gives a timeout of 2^(m-1) frames or microframes
// - ep0 halts when naks continue longer than the programmed limit
// - limit value 0 or 1 disables the nak timeout
// - type and nak limit settings apply only in host mode
module uht_regs
   import uht_pkg::*;
(
   input  wire logic                  CLK,
   input  wire logic                  RST_N,
   input  wire logic [UHT_ADDR_W-1:0] ADDR,
   input  wire logic [15:0]           WDATA,
   input  wire logic                  WR_EN,
   input  wire logic                  RD_EN,
   output logic      [15:0]           RDATA,
   input  wire logic                  HOST_MODE,
   input  wire logic [UHT_CNT_W-1:0]  FIFO_BYTE_COUNT,
   input  wire logic                  RX_PACKET_READY,
   input  wire logic                  FRAME_TICK,
   input  wire logic                  EP0_NAK_SEEN,
   input  wire logic                  EP0_DATA_SEEN,
   output logic      [1:0]            EP0_SPEED,
   output logic      [1:0]            TX_SPEED,
   output logic      [1:0]            TX_PROTOCOL,
   output logic      [3:0]            TX_TARGET_ENDPOINT,
   output logic                       SPEED_ILLEGAL,
   output logic                       EP0_HALTED,
   output logic                       IRQ
);
   logic [7:0]              ep0_type_r;
   logic [7:0]              tx_type_r;
   logic [UHT_NAKLIM_W-1:0] nak_limit_r;
   logic [UHT_CNT_W-1:0]    rx_count_r;
   logic                    rdy_d_r;
   logic [15:0]             rdata_nxt;
   logic                    wr_ep0;
   logic                    wr_tx;
   logic                    wr_nak;
   logic                    halt_pulse;
   logic [UHT_IRQ_W-1:0]    irq_stat;
   logic [UHT_IRQ_W-1:0]    irq_mask;
   logic [UHT_IRQ_W-1:0]    events;
   logic                    wr_ctrl;
   logic                    wr_stat;
   logic                    wr_mask;
   logic                    halt_clr;
   logic                    rx_rise;
   logic [UHT_NAKLIM_W-1:0] nak_limit_eff;

   function automatic logic hit(input logic [UHT_ADDR_W-1:0] a,
                                input logic [3:0]            idx);
      hit = (a == idx);
   endfunction

   function automatic logic [1:0] speed_of(input logic [7:0] t);
      speed_of = t[UHT_SPEED_LSB +: 2];
   endfunction

   function automatic logic speed_bad(input logic [7:0] t);
      speed_bad = (speed_of(t) == UHT_SPEED_ILLEGAL);
   endfunction

   // exponents above the largest valid one act as the largest
   function automatic logic [UHT_NAKLIM_W-1:0] clamp_limit(
      input logic [UHT_NAKLIM_W-1:0] m);
      clamp_limit = (m > UHT_NAKLIM_MAX) ? UHT_NAKLIM_MAX : m;
   endfunction

   assign wr_ep0 = WR_EN && hit(ADDR, UHT_IDX_EP0_TYPE);
   assign wr_tx  = WR_EN && hit(ADDR, UHT_IDX_TX_TYPE);
   assign wr_nak = WR_EN && hit(ADDR, UHT_IDX_NAK_LIM0);
   assign wr_ctrl = WR_EN && hit(ADDR, UHT_IDX_EP0_CTRL);
   assign wr_stat = WR_EN && hit(ADDR, UHT_IDX_IRQ_STAT);
   assign wr_mask = WR_EN && hit(ADDR, UHT_IDX_IRQ_MASK);
   assign halt_clr = wr_ctrl && WDATA[0];

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ep0_type_r <= UHT_EP0_TYPE_RST;
      end else if (wr_ep0) begin
         ep0_type_r <= {speed_of(WDATA[7:0]), 6'h00};
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         tx_type_r <= UHT_TX_TYPE_RST;
      end else if (wr_tx) begin
         tx_type_r <= WDATA[7:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         nak_limit_r <= UHT_NAKLIM_RST;
      end else if (wr_nak) begin
         nak_limit_r <= WDATA[UHT_NAKLIM_W-1:0];
      end
   end

   // count samples the fifo each cycle; reads as zero from the cycle after ready is low
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rx_count_r <= '0;
      end else begin
         rx_count_r <= RX_PACKET_READY ? FIFO_BYTE_COUNT : '0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rdy_d_r <= 1'b0;
      end else begin
         rdy_d_r <= RX_PACKET_READY;
      end
   end

   uht_nak_timer u_nak (
      .clk        (CLK),
      .rst_n      (RST_N),
      .enable     (HOST_MODE),
      .limit      (nak_limit_eff),
      .frame_tick (FRAME_TICK),
      .nak_seen   (EP0_NAK_SEEN),
      .data_seen  (EP0_DATA_SEEN),
      .halt_clr   (halt_clr),
      .halt       (EP0_HALTED),
      .halt_pulse (halt_pulse)
   );

   // a rising ready flag is the receive event
   assign rx_rise       = RX_PACKET_READY && !rdy_d_r;
   assign events        = {rx_rise, halt_pulse};
   assign nak_limit_eff = clamp_limit(nak_limit_r);

   uht_irq u_irq (
      .clk     (CLK),
      .rst_n   (RST_N),
      .events  (events),
      .stat_wr (wr_stat),
      .mask_wr (wr_mask),
      .wdata   (WDATA[UHT_IRQ_W-1:0]),
      .status  (irq_stat),
      .mask    (irq_mask),
      .irq     (IRQ)
   );

   // settings reach the engine only in host mode, one register per field
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         EP0_SPEED <= UHT_SPEED_ILLEGAL;
      end else if (!HOST_MODE) begin
         EP0_SPEED <= UHT_SPEED_ILLEGAL;
      end else begin
         EP0_SPEED <= speed_of(ep0_type_r);
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         TX_SPEED <= UHT_SPEED_ILLEGAL;
      end else if (!HOST_MODE) begin
         TX_SPEED <= UHT_SPEED_ILLEGAL;
      end else begin
         TX_SPEED <= speed_of(tx_type_r);
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         TX_PROTOCOL <= UHT_PROTOCOL_SELECT_CTRL;
      end else if (!HOST_MODE) begin
         TX_PROTOCOL <= UHT_PROTOCOL_SELECT_CTRL;
      end else begin
         TX_PROTOCOL <= tx_type_r[UHT_PROTOCOL_SELECT_LSB +: 2];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         TX_TARGET_ENDPOINT <= 4'h0;
      end else if (!HOST_MODE) begin
         TX_TARGET_ENDPOINT <= 4'h0;
      end else begin
         TX_TARGET_ENDPOINT <= tx_type_r[UHT_TEP_LSB +: 4];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         SPEED_ILLEGAL <= 1'b0;
      end else if (!HOST_MODE) begin
         SPEED_ILLEGAL <= 1'b0;
      end else begin
         SPEED_ILLEGAL <= speed_bad(ep0_type_r) || speed_bad(tx_type_r);
      end
   end

   always_comb begin
      rdata_nxt = 16'h0000;
      case (ADDR)
         UHT_IDX_RX_COUNT: rdata_nxt = {3'h0, rx_count_r};
         UHT_IDX_EP0_TYPE: rdata_nxt = {8'h00, ep0_type_r};
         UHT_IDX_TX_TYPE:  rdata_nxt = {8'h00, tx_type_r};
         UHT_IDX_NAK_LIM0: rdata_nxt = {11'h000, nak_limit_r};
         UHT_IDX_IRQ_STAT: rdata_nxt = {14'h0000, irq_stat};
         UHT_IDX_IRQ_MASK: rdata_nxt = {14'h0000, irq_mask};
         UHT_IDX_EP0_CTRL: rdata_nxt = {15'h0000, EP0_HALTED};
         default:          rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         RDATA <= 16'h0000;
      end else if (RD_EN) begin
         RDATA <= rdata_nxt;
      end else begin
         RDATA <= 16'h0000;
      end
   end
endmodule

// ---- verification/uht_regs_monitor.sv ----
// assertions on the register port and the host config outputs
// bound to uht_regs; sees its ports only
`timescale 1ns/100ps
module uht_regs_monitor
   import uht_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic [3:0]  ADDR,
   input wire logic [15:0] WDATA,
   input wire logic        WR_EN,
   input wire logic        RD_EN,
   input wire logic [15:0] RDATA,
   input wire logic        HOST_MODE,
   input wire logic        RX_PACKET_READY,
   input wire logic        FRAME_TICK,
   input wire logic [1:0]  EP0_SPEED,
   input wire logic [1:0]  TX_SPEED,
   input wire logic [1:0]  TX_PROTOCOL,
   input wire logic [3:0]  TX_TARGET_ENDPOINT,
   input wire logic        SPEED_ILLEGAL,
   input wire logic        EP0_HALTED
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   sequence s_rd(logic [3:0] a); $past(RD_EN) && $past(ADDR) == a; endsequence
   property p_rd_idle; !$past(RD_EN) |-> RDATA == 16'h0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("rdata set outside a read");
   property p_cnt_rsvd; s_rd(UHT_IDX_RX_COUNT) |-> RDATA[15:13] == 3'h0; endproperty
   a_cnt_rsvd: assert property (p_cnt_rsvd) else $error("count top bits set");
   property p_cnt_gate;
      s_rd(UHT_IDX_RX_COUNT) and !$past(RX_PACKET_READY) and !$past(RX_PACKET_READY, 2)
      |-> RDATA == 16'h0000;
   endproperty
   a_cnt_gate: assert property (p_cnt_gate) else $error("count shown without ready");
   property p_nak_rsvd; s_rd(UHT_IDX_NAK_LIM0) |-> RDATA[15:5] == 11'h000; endproperty
   a_nak_rsvd: assert property (p_nak_rsvd) else $error("nak limit top bits set");
   property p_host_off;
      !$past(HOST_MODE) |-> {EP0_SPEED, TX_SPEED, TX_PROTOCOL, TX_TARGET_ENDPOINT} == 10'h000;
   endproperty
   a_host_off: assert property (p_host_off) else $error("config out of host mode");
   property p_illegal;
      SPEED_ILLEGAL == ($past(HOST_MODE) && (EP0_SPEED == 2'h0 || TX_SPEED == 2'h0));
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal speed flag wrong");
   property p_halt_tick; $rose(EP0_HALTED) |-> $past(FRAME_TICK); endproperty
   a_halt_tick: assert property (p_halt_tick) else $error("halt off a frame tick");
   property p_tx_wr;
      WR_EN && ADDR == UHT_IDX_TX_TYPE ##1 HOST_MODE && !(WR_EN && ADDR == UHT_IDX_TX_TYPE)
      |=> {TX_SPEED, TX_PROTOCOL, TX_TARGET_ENDPOINT} == $past(WDATA[7:0], 2);
   endproperty
   a_tx_wr: assert property (p_tx_wr) else $error("tx config not applied");
   c_halt: cover property ($rose(EP0_HALTED));
   c_illegal: cover property (SPEED_ILLEGAL);
   c_cnt: cover property (s_rd(UHT_IDX_RX_COUNT) and $past(RX_PACKET_READY));
endmodule
bind uht_regs uht_regs_monitor mon (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
   .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA), .HOST_MODE(HOST_MODE),
   .RX_PACKET_READY(RX_PACKET_READY), .FRAME_TICK(FRAME_TICK), .EP0_SPEED(EP0_SPEED),
   .TX_SPEED(TX_SPEED), .TX_PROTOCOL(TX_PROTOCOL), .TX_TARGET_ENDPOINT(TX_TARGET_ENDPOINT),
   .SPEED_ILLEGAL(SPEED_ILLEGAL), .EP0_HALTED(EP0_HALTED));

// ---- verification/uht_regs_test.sv ----
// register-level bench of uht_regs with a target model driving frame events
// assumes frames of 8 cycles from the model
`timescale 1ns/100ps
module uht_regs_test
   import uht_pkg::*;
;
   logic        CLK, RST_N, WR_EN, RD_EN, HOST_MODE, RX_PACKET_READY, nak_on, data_req;
   logic        FRAME_TICK, EP0_NAK_SEEN, EP0_DATA_SEEN, SPEED_ILLEGAL, EP0_HALTED, IRQ;
   logic [3:0]  ADDR, TX_TARGET_ENDPOINT;
   logic [15:0] WDATA, RDATA;
   logic [12:0] FIFO_BYTE_COUNT;
   logic [1:0]  EP0_SPEED, TX_SPEED, TX_PROTOCOL;
   logic [7:0]  v;
   int          err_total, cmp_count, i;
   uht_regs dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR_EN(WR_EN),
      .RD_EN(RD_EN), .RDATA(RDATA), .HOST_MODE(HOST_MODE), .FIFO_BYTE_COUNT(FIFO_BYTE_COUNT),
      .RX_PACKET_READY(RX_PACKET_READY), .FRAME_TICK(FRAME_TICK), .EP0_NAK_SEEN(EP0_NAK_SEEN),
      .EP0_DATA_SEEN(EP0_DATA_SEEN), .EP0_SPEED(EP0_SPEED), .TX_SPEED(TX_SPEED),
      .TX_PROTOCOL(TX_PROTOCOL), .TX_TARGET_ENDPOINT(TX_TARGET_ENDPOINT),
      .SPEED_ILLEGAL(SPEED_ILLEGAL), .EP0_HALTED(EP0_HALTED), .IRQ(IRQ));
   uht_target_model tgt (.clk(CLK), .rst_n(RST_N), .nak_on(nak_on), .data_req(data_req),
      .frame_tick(FRAME_TICK), .nak_seen(EP0_NAK_SEEN), .data_seen(EP0_DATA_SEEN));
   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   task automatic stop_test();
      $display("errors %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge CLK);
      WR_EN <= 1'b1;
      ADDR  <= a;
      WDATA <= d;
      @(posedge CLK);
      WR_EN <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [3:0] a, logic [15:0] exp);
      @(posedge CLK);
      RD_EN <= 1'b1;
      ADDR  <= a;
      @(posedge CLK);
      RD_EN <= 1'b0;
      #1;
      chk("rdata", exp, RDATA);
   endtask
   task automatic frames(int n);
      repeat (n * 8) @(posedge CLK);
      #1;
   endtask
   initial begin
      {RST_N, WR_EN, RD_EN, HOST_MODE, RX_PACKET_READY, nak_on, data_req} = 7'h00;
      {ADDR, WDATA, FIFO_BYTE_COUNT} = 33'h0;
      err_total = 0;
      cmp_count = 0;
      repeat (10) @(posedge CLK);
      RST_N <= 1'b1;
      for (i = 0; i < 16; i++) rd(i[3:0], 16'h0000);
      FIFO_BYTE_COUNT <= 13'h1FFF;
      RX_PACKET_READY <= 1'b1;
      frames(1);
      rd(UHT_IDX_RX_COUNT, 16'h1FFF);
      RX_PACKET_READY <= 1'b0;
      frames(1);
      rd(UHT_IDX_RX_COUNT, 16'h0000);
      rd(UHT_IDX_IRQ_STAT, 16'h0002);
      chk("irq", 16'h0, {15'h0, IRQ});
      wr(UHT_IDX_IRQ_MASK, 16'h0003);
      chk("irq", 16'h1, {15'h0, IRQ});
      wr(UHT_IDX_IRQ_STAT, 16'h0002);
      rd(UHT_IDX_IRQ_STAT, 16'h0000);
      chk("irq", 16'h0, {15'h0, IRQ});
      HOST_MODE <= 1'b1;
      for (i = 0; i < 4; i++) begin
         v = {i[1:0], ~i[1:0], 4'hC - i[3:0]};
         wr(UHT_IDX_EP0_TYPE, {8'hFF, ~i[1:0], 6'h3F});
         wr(UHT_IDX_TX_TYPE, {8'hFF, v});
         rd(UHT_IDX_EP0_TYPE, {8'h00, ~i[1:0], 6'h00});
         rd(UHT_IDX_TX_TYPE, {8'h00, v});
         chk("tx", {8'h00, v}, {8'h00, TX_SPEED, TX_PROTOCOL, TX_TARGET_ENDPOINT});
         chk("ep0", {14'h0, ~i[1:0]}, {14'h0, EP0_SPEED});
         chk("illegal", {15'h0, i == 0 || i == 3}, {15'h0, SPEED_ILLEGAL});
      end
      wr(UHT_IDX_NAK_LIM0, 16'hFFFF);
      rd(UHT_IDX_NAK_LIM0, 16'h001F);
      wr(UHT_IDX_NAK_LIM0, 16'h0002);
      nak_on <= 1'b1;
      frames(1);
      chk("halt", 16'h0, {15'h0, EP0_HALTED});
      for (i = 0; i < 32 && EP0_HALTED !== 1'b1; i++) begin
         @(posedge CLK);
         #1;
      end
      chk("halt", 16'h1, {15'h0, EP0_HALTED});
      if (EP0_HALTED !== 1'b1) begin
         stop_test();
      end
      chk("irq", 16'h1, {15'h0, IRQ});
      nak_on <= 1'b0;
      rd(UHT_IDX_EP0_CTRL, 16'h0001);
      wr(UHT_IDX_EP0_CTRL, 16'h0001);
      wr(UHT_IDX_IRQ_STAT, 16'h0001);
      rd(UHT_IDX_IRQ_STAT, 16'h0000);
      chk("halt", 16'h0, {15'h0, EP0_HALTED});
      frames(3);
      chk("halt", 16'h0, {15'h0, EP0_HALTED});
      for (i = 0; i < 2; i++) begin
         wr(UHT_IDX_NAK_LIM0, i[15:0]);
         nak_on <= 1'b1;
         frames(6);
         chk("halt", 16'h0, {15'h0, EP0_HALTED});
         nak_on <= 1'b0;
      end
      wr(UHT_IDX_NAK_LIM0, 16'h0002);
      {nak_on, data_req} <= 2'h3;
      frames(6);
      chk("halt", 16'h0, {15'h0, EP0_HALTED});
      {nak_on, data_req} <= 2'h0;
      HOST_MODE <= 1'b0;
      frames(1);
      chk("cfg", 16'h0, {6'h0, EP0_SPEED, TX_SPEED, TX_PROTOCOL, TX_TARGET_ENDPOINT});
      stop_test();
   end
endmodule

// ---- verification/uht_target_model.sv ----
// stand-in for the attached usb target: frame ticks and endpoint 0 answers
// assumes the bench commands nak streams and data answers
`timescale 1ns/100ps
module uht_target_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic nak_on,
   input  wire logic data_req,
   output logic      frame_tick,
   output logic      nak_seen,
   output logic      data_seen
);
   logic [2:0] cyc_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cyc_r      <= 3'h0;
         frame_tick <= 1'b0;
         nak_seen   <= 1'b0;
         data_seen  <= 1'b0;
      end else begin
         cyc_r      <= cyc_r + 3'h1;
         frame_tick <= cyc_r == 3'h7;
         nak_seen   <= nak_on && cyc_r == 3'h2;
         data_seen  <= data_req && cyc_r == 3'h5;
      end
   end
endmodule
